// [hdl/sts1_ptr_params.svh]
// Register map, field positions, reset values and pointer constants.
`ifndef STS1_PTR_PARAMS_SVH
`define STS1_PTR_PARAMS_SVH
`define OFS_PATH_CTRL   4'h0
`define OFS_ARB_HIGH    4'h4
`define OFS_ARB_LOW     4'h8
`define OFS_PTR_STATUS  4'hc
`define BIT_SINGLE_NDF  0
`define BIT_CONT_NDF    1
`define BIT_POS_STUFF   2
`define BIT_NEG_STUFF   3
`define BIT_CHECK_STUFF 4
`define BIT_PTR_FORCE   5
`define RST_PATH_CTRL   8'h00
`define RST_ARB_HIGH    8'h00
`define RST_ARB_LOW     8'h00
`define RST_POINTER     10'h000
`define NDF_NORMAL      4'h6
`define NDF_SET         4'h9
`define SS_NORMAL       2'h0
`define PTR_MAX         10'h30e
`define I_BIT_MASK      10'h2aa
`define D_BIT_MASK      10'h155
`define GAP_FRAMES      2'h3
`endif

// [hdl/sts1_ptr_pkg.sv]
// Types shared by the transmit pointer adjustment controller.
package sts1_ptr_pkg;
   // Outbound H1/H2 pointer word, H1 in the upper byte.
   typedef struct packed {
      logic [3:0] ndf;
      logic [1:0] ss;
      logic [9:0] value;
   } ptr_word_type;
   // Requests waiting for the next frame start.
   typedef struct packed {
      logic force_ptr;
      logic single_ndf;
      logic pos_stuff;
      logic neg_stuff;
   } pend_type;
endpackage

// [hdl/sts1_tx_pointer_adjust_ctrl.sv]
// Transmit STS-1 pointer adjustment controller with Avalon-MM registers.
// Functional notes
// R1: Positive-stuff trigger puts one stuff byte right after the H3 position.
// R2: Frame with a positive stuff carries the pointer with I bits inverted.
// R3: After a positive stuff the pointer is one higher and stays so.
// R4: Positive-stuff trigger bit clears itself once the event is taken.
// R5: Negative-stuff trigger puts one payload byte into the H3 position.
// R6: Frame with a negative stuff carries the pointer with D bits inverted.
// R7: After a negative stuff the pointer is one lower and stays so.
// R8: Negative-stuff trigger bit clears itself once the event is taken.
// R9: Rising single-NDF bit sets H1 N bits to 1001 next frame.
// R10: Single NDF event loads the pointer from the two arbitrary registers.
// R11: Software writes the pointer into both arbitrary registers before.
// R12: Rising force bit copies NDF, SS and pointer from arbitrary registers.
// R13: With check-stuff on, events wait until three clear frames have passed.
// R14: Requests made mid-frame take effect at the next frame start.
`include "sts1_ptr_params.svh"
module sts1_tx_pointer_adjust_ctrl (
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        srst,
   // Avalon-MM slave.
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Frame timing, a pulse in the cycle before the H1 byte.
   input  wire logic        frame_start,
   // Outbound overhead for the current frame.
   output logic      [7:0]  h1_q,
   output logic      [7:0]  h2_q,
   output logic             h3_payload_q,
   output logic             pos_stuff_q,
   output logic      [9:0]  ptr_q
);

   // Reset pointer, split over the H1 and H2 bytes at reset.
   localparam logic [9:0] RST_PTR = `RST_POINTER;

   // Registers and internal state.
   logic [7:0]                 ctrl_q;
   logic [7:0]                 arb_high_q;
   logic [7:0]                 arb_low_q;
   sts1_ptr_pkg::pend_type     pend_q;
   logic [1:0]                 gap_q;
   logic                       wr_en;
   logic                       rd_en;
   logic                       ctrl_wr;
   logic [7:0]                 wbyte;
   logic                       allowed;
   logic                       go;
   logic                       act_frc;
   logic                       act_ndf;
   logic                       act_pos;
   logic                       act_neg;
   logic [9:0]                 arb_ptr;
   sts1_ptr_pkg::ptr_word_type word;

   // Pointer increment, wrapping past the top of the legal range.
   function automatic logic [9:0] ptr_inc(input logic [9:0] p);
      ptr_inc = (p >= `PTR_MAX) ? 10'h000 : p + 10'h001;
   endfunction

   // Pointer decrement, wrapping below zero to the top of the range.
   function automatic logic [9:0] ptr_dec(input logic [9:0] p);
      ptr_dec = (p == 10'h000) ? `PTR_MAX : p - 10'h001;
   endfunction

   // Packs the three pointer fields into the H1/H2 word.
   function automatic sts1_ptr_pkg::ptr_word_type pack(
      input logic [3:0] n,
      input logic [1:0] s,
      input logic [9:0] v);
      pack.ndf   = n;
      pack.ss    = s;
      pack.value = v;
   endfunction

   // A transfer completes at the edge where waitrequest is sampled low.
   assign wr_en   = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign rd_en   = avs_read && avs_waitrequest;
   assign ctrl_wr = wr_en && (avs_address == `OFS_PATH_CTRL);
   assign wbyte   = avs_writedata[7:0];
   assign arb_ptr = {arb_high_q[1:0], arb_low_q}; // [R11]

   // Event selection at the frame start, force first, negative stuff last.
   assign allowed = !ctrl_q[`BIT_CHECK_STUFF] || (gap_q == `GAP_FRAMES); // [R13]
   assign go      = frame_start && allowed; // [R14]
   assign act_frc = go && pend_q.force_ptr;
   assign act_ndf = go && pend_q.single_ndf && !pend_q.force_ptr;
   assign act_pos = go && pend_q.pos_stuff && !pend_q.force_ptr
                    && !pend_q.single_ndf;
   assign act_neg = go && pend_q.neg_stuff && !pend_q.force_ptr
                    && !pend_q.single_ndf && !pend_q.pos_stuff;

   // Bus handshake: one wait cycle, then the transfer completes.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      end
   end

   // Read data is loaded in the wait cycle so it stands at completion.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (rd_en) begin
         unique case (avs_address)
            `OFS_PATH_CTRL:  avs_readdata <= {24'h00_0000, 2'h0,
                                ctrl_q[`BIT_PTR_FORCE],
                                ctrl_q[`BIT_CHECK_STUFF],
                                pend_q.neg_stuff, pend_q.pos_stuff,
                                ctrl_q[`BIT_CONT_NDF],
                                ctrl_q[`BIT_SINGLE_NDF]};
            `OFS_ARB_HIGH:   avs_readdata <= {24'h00_0000, arb_high_q};
            `OFS_ARB_LOW:    avs_readdata <= {24'h00_0000, arb_low_q};
            `OFS_PTR_STATUS: avs_readdata <= {22'h0, ptr_q};
            default:         avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // Software-written registers; stuff bits are not stored here.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ctrl_q     <= `RST_PATH_CTRL;
         arb_high_q <= `RST_ARB_HIGH;
         arb_low_q  <= `RST_ARB_LOW;
      end else if (wr_en) begin
         if (avs_address == `OFS_PATH_CTRL) begin
            ctrl_q <= wbyte & 8'h33;
         end
         if (avs_address == `OFS_ARB_HIGH) begin
            arb_high_q <= wbyte;
         end
         if (avs_address == `OFS_ARB_LOW) begin
            arb_low_q <= wbyte;
         end
      end
   end

   // Pending requests; a new request in the cycle it is taken survives.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pend_q <= '0;
      end else begin
         if (act_frc) begin
            pend_q.force_ptr <= 1'b0;
         end
         if (act_ndf) begin
            pend_q.single_ndf <= 1'b0;
         end
         if (act_pos) begin
            pend_q.pos_stuff <= 1'b0; // [R4]
         end
         if (act_neg) begin
            pend_q.neg_stuff <= 1'b0; // [R8]
         end
         if (ctrl_wr && wbyte[`BIT_PTR_FORCE]
             && !ctrl_q[`BIT_PTR_FORCE]) begin
            pend_q.force_ptr <= 1'b1; // [R12]
         end
         if (ctrl_wr && wbyte[`BIT_SINGLE_NDF]
             && !ctrl_q[`BIT_SINGLE_NDF]) begin
            pend_q.single_ndf <= 1'b1; // [R9]
         end
         if (ctrl_wr && wbyte[`BIT_POS_STUFF]) begin
            pend_q.pos_stuff <= 1'b1; // [R1]
         end
         if (ctrl_wr && wbyte[`BIT_NEG_STUFF]) begin
            pend_q.neg_stuff <= 1'b1; // [R5]
         end
      end
   end

   // Frames since the last event, saturating so a long quiet run is fine.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         gap_q <= `GAP_FRAMES;
      end else if (act_frc || act_ndf || act_pos || act_neg) begin
         gap_q <= 2'h0; // [R13]
      end else if (frame_start && gap_q != `GAP_FRAMES) begin
         gap_q <= gap_q + 2'h1;
      end
   end

   // Word for the coming frame, chosen from the event taken.
   always_comb begin
      word = pack(`NDF_NORMAL, `SS_NORMAL, ptr_q);
      if (act_frc) begin
         word = {arb_high_q, arb_low_q}; // [R12]
      end else if (act_ndf) begin
         word = pack(`NDF_SET, `SS_NORMAL, arb_ptr); // [R9] [R10]
      end else if (act_pos) begin
         word = pack(`NDF_NORMAL, `SS_NORMAL, ptr_q ^ `I_BIT_MASK); // [R2]
      end else if (act_neg) begin
         word = pack(`NDF_NORMAL, `SS_NORMAL, ptr_q ^ `D_BIT_MASK); // [R6]
      end
   end

   // Outbound overhead changes only at a frame start, never mid-frame.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         h1_q         <= {`NDF_NORMAL, `SS_NORMAL, RST_PTR[9:8]};
         h2_q         <= RST_PTR[7:0];
         h3_payload_q <= 1'b0;
         pos_stuff_q  <= 1'b0;
      end else if (frame_start) begin
         h1_q         <= word[15:8]; // [R14]
         h2_q         <= word[7:0];
         h3_payload_q <= act_neg; // [R5]
         pos_stuff_q  <= act_pos; // [R1]
      end
   end

   // Pointer carried into later frames.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ptr_q <= `RST_POINTER;
      end else if (act_frc || act_ndf) begin
         ptr_q <= arb_ptr; // [R10] [R12]
      end else if (act_pos) begin
         ptr_q <= ptr_inc(ptr_q); // [R3]
      end else if (act_neg) begin
         ptr_q <= ptr_dec(ptr_q); // [R7]
      end
   end

   // Checks on the behaviour above.
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);

   property p_pos_byte;
      act_pos |=> pos_stuff_q && !h3_payload_q;
   endproperty
   a_pos_byte: assert property (p_pos_byte) // [R1]
      else $error("stuff byte missing after positive stuff");

   property p_pos_ibits;
      act_pos |=> {h1_q[1:0], h2_q} == ($past(ptr_q) ^ `I_BIT_MASK);
   endproperty
   a_pos_ibits: assert property (p_pos_ibits) // [R2]
      else $error("I bits not inverted");

   property p_pos_inc;
      act_pos |=> ptr_q == ptr_inc($past(ptr_q));
   endproperty
   a_pos_inc: assert property (p_pos_inc) // [R3]
      else $error("pointer not incremented");

   property p_pos_clear;
      act_pos && !ctrl_wr |=> !pend_q.pos_stuff;
   endproperty
   a_pos_clear: assert property (p_pos_clear) // [R4]
      else $error("positive stuff request not cleared");

   property p_neg_byte;
      act_neg |=> h3_payload_q && !pos_stuff_q;
   endproperty
   a_neg_byte: assert property (p_neg_byte) // [R5]
      else $error("H3 payload missing after negative stuff");

   property p_neg_dbits;
      act_neg |=> {h1_q[1:0], h2_q} == ($past(ptr_q) ^ `D_BIT_MASK);
   endproperty
   a_neg_dbits: assert property (p_neg_dbits) // [R6]
      else $error("D bits not inverted");

   property p_neg_dec;
      act_neg |=> ptr_q == ptr_dec($past(ptr_q));
   endproperty
   a_neg_dec: assert property (p_neg_dec) // [R7]
      else $error("pointer not decremented");

   property p_neg_clear;
      act_neg && !ctrl_wr |=> !pend_q.neg_stuff;
   endproperty
   a_neg_clear: assert property (p_neg_clear) // [R8]
      else $error("negative stuff request not cleared");

   property p_ndf;
      act_ndf |=> h1_q[7:4] == `NDF_SET && ptr_q == $past(arb_ptr);
   endproperty
   a_ndf: assert property (p_ndf) // [R9]
      else $error("single NDF word wrong");

   property p_force;
      act_frc |=> {h1_q, h2_q} == $past({arb_high_q, arb_low_q});
   endproperty
   a_force: assert property (p_force) // [R12]
      else $error("forced pointer word wrong");

   property p_gap;
      ctrl_q[`BIT_CHECK_STUFF] && frame_start && gap_q != `GAP_FRAMES
         |=> !pos_stuff_q && !h3_payload_q;
   endproperty
   a_gap: assert property (p_gap) // [R13]
      else $error("event inside guard frames");

   property p_hold;
      !frame_start |=> $stable(h1_q) && $stable(h2_q) && $stable(pos_stuff_q);
   endproperty
   a_hold: assert property (p_hold) // [R14]
      else $error("overhead changed mid-frame");

endmodule

// [sim/sts1_frame_source.sv]
// Downstream frame timing source that paces the pointer controller.
module sts1_frame_source #(
   parameter int FRAME_LEN = 32
) (
   // Clock and reset.
   input  wire logic sys_clk,
   input  wire logic srst,
   // Frame timing towards the block.
   output logic      frame_start
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_q;

   // One pulse per frame; short frames keep the run brief.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cnt_q       <= 0;
         frame_start <= 1'b0;
      end else begin
         cnt_q       <= (cnt_q == FRAME_LEN - 1) ? 0 : cnt_q + 1;
         frame_start <= (cnt_q == FRAME_LEN - 1);
      end
   end
endmodule

// [sim/sts1_tx_pointer_adjust_ctrl_tb.sv]
// Self-checking bench for the transmit pointer adjustment controller.
module sts1_tx_pointer_adjust_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk;
   logic        srst;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        frame_start;
   logic [7:0]  h1_q;
   logic [7:0]  h2_q;
   logic        h3_payload_q;
   logic        pos_stuff_q;
   logic [9:0]  ptr_q;
   int          err_total = 0;
   int          n_compared = 0;

   sts1_tx_pointer_adjust_ctrl i_dut (.sys_clk(sys_clk), .srst(srst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .frame_start(frame_start),
      .h1_q(h1_q), .h2_q(h2_q), .h3_payload_q(h3_payload_q),
      .pos_stuff_q(pos_stuff_q), .ptr_q(ptr_q));
   sts1_frame_source i_frame (.sys_clk(sys_clk), .srst(srst),
      .frame_start(frame_start));

   // Clock of 5 ns period.
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One bus transfer; the request holds until waitrequest is seen low.
   task automatic bus(input logic wr, input logic [3:0] adr,
                      input logic [7:0] wd, input logic [3:0] be,
                      output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address    <= adr;
      avs_writedata  <= {24'h000000, wd};
      avs_byteenable <= be;
      avs_write      <= wr;
      avs_read       <= !wr;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      if (n >= 50) chk(32'h0, 32'h1);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] adr, input logic [7:0] d);
      logic [31:0] rd;
      bus(1'b1, adr, d, 4'hf, rd);
   endtask

   task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, adr, 8'h00, 4'hf, rd);
      chk(rd, exp);
   endtask

   // Waits for a frame start and lets the edge's updates land.
   task automatic next_frame();
      do @(posedge sys_clk); while (frame_start !== 1'b1);
      #1;
   endtask

   // Compares the whole overhead word, pointer and both stuff flags.
   task automatic chk_oh(input logic [15:0] w, input logic [9:0] p,
                         input logic pos, input logic neg);
      chk({h1_q, h2_q}, w);
      chk(ptr_q, p);
      chk({pos_stuff_q, h3_payload_q}, {pos, neg});
   endtask

   task automatic t_reset();
      logic [31:0] rd;
      chk_oh(16'h6000, 10'h000, 1'b0, 1'b0);
      for (int a = 0; a < 16; a += 4) rd_chk(a[3:0], 32'h0);
      // A write without byte lane 0 must leave the register alone.
      bus(1'b1, 4'h8, 8'h5a, 4'he, rd);
      rd_chk(4'h8, 32'h0);
      // Unused bits read zero; the continuous NDF bit is only stored.
      wr(4'h0, 8'hc2);
      rd_chk(4'h0, 32'h02);
      wr(4'h0, 8'h00);
      $display("reset test done");
   endtask

   task automatic t_neg();
      next_frame();
      wr(4'h0, 8'h08);
      rd_chk(4'h0, 32'h08);
      next_frame();
      chk_oh(16'h6155, 10'h30e, 1'b0, 1'b1);
      rd_chk(4'h0, 32'h00);
      next_frame();
      chk_oh(16'h630e, 10'h30e, 1'b0, 1'b0);
      $display("negative stuff test done");
   endtask

   task automatic t_pos();
      wr(4'h0, 8'h04);
      rd_chk(4'h0, 32'h04);
      next_frame();
      chk_oh(16'h61a4, 10'h000, 1'b1, 1'b0);
      rd_chk(4'h0, 32'h00);
      next_frame();
      chk_oh(16'h6000, 10'h000, 1'b0, 1'b0);
      rd_chk(4'hc, 32'h000);
      $display("positive stuff test done");
   endtask

   task automatic t_ndf();
      wr(4'h4, 8'hf2);
      wr(4'h8, 8'h34);
      wr(4'h0, 8'h01);
      next_frame();
      chk_oh(16'h9234, 10'h234, 1'b0, 1'b0);
      next_frame();
      chk_oh(16'h6234, 10'h234, 1'b0, 1'b0);
      wr(4'h0, 8'h00);
      $display("single ndf test done");
   endtask

   task automatic t_force();
      wr(4'h4, 8'ha5);
      wr(4'h8, 8'h0f);
      wr(4'h0, 8'h20);
      next_frame();
      chk_oh(16'ha50f, 10'h10f, 1'b0, 1'b0);
      next_frame();
      chk_oh(16'h610f, 10'h10f, 1'b0, 1'b0);
      $display("pointer force test done");
   endtask

   // The force frame counts as an event, so the stuff must wait.
   task automatic t_guard();
      wr(4'h0, 8'h14);
      rd_chk(4'h0, 32'h14);
      for (int i = 0; i < 2; i++) begin
         next_frame();
         chk(pos_stuff_q, 1'b0);
      end
      next_frame();
      chk_oh(16'h63a5, 10'h110, 1'b1, 1'b0);
      wr(4'h0, 8'h00);
      $display("check stuff test done");
   endtask

   task automatic wrap_up();
      $display("compared %0d, wrong %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      srst           = 1'b1;
      avs_address    = 4'h0;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = 32'h0;
      avs_byteenable = 4'hf;
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      #1;
      t_reset();
      t_neg();
      t_pos();
      t_ndf();
      t_force();
      t_guard();
      wrap_up();
   end

   // About 400 cycles are needed; the limit leaves ample margin.
   initial begin
      #20000;
      err_total++;
      wrap_up();
   end
endmodule
